// ### cies_core.sv
/*
  Execute stage for the OR, store, copy, idle, return from irq and rotate operations.
  Assumes the fetch unit holds an operation on the inputs until READY is seen with it.
*/
`timescale 1ns/1ns
`default_nettype none
module cies_core
  import cies_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic INSTR_VALID,
  input wire logic [2:0] INSTR_OP,
  input wire logic [CIES_ADDR_W-1:0] INSTR_ADDR,
  input wire logic INSTR_DEST,
  input wire logic [CIES_PC_W-1:0] STACK_TOP_ENTRY,
  input wire logic GLOBAL_IRQ_CLEAR,
  output logic READY,
  output logic [CIES_DATA_W-1:0] ACCUM,
  output logic ZERO_FLAG,
  output logic CARRY_FLAG,
  output logic GLOBAL_IRQ_ENABLE,
  output logic PC_LOAD,
  output logic [CIES_PC_W-1:0] PC_VALUE,
  output logic STACK_POP,
  output logic FETCH_FLUSH
);
  cies_mem_if mif ();

  cies_file_ram u_ram (
    .clk(SYS_CLK),
    .port(mif.mem)
  );

  cies_state_t state_reg, state_next;
  logic [2:0] op_reg;
  logic [CIES_ADDR_W-1:0] addr_reg;
  logic dest_reg;
  logic ready_reg;
  logic [CIES_DATA_W-1:0] accum_reg, accum_next;
  logic zero_reg, zero_next;
  logic carry_reg, carry_next;
  logic irq_en_reg, irq_en_next;
  logic pc_load_reg;
  logic [CIES_PC_W-1:0] pc_value_reg;
  logic pop_reg;
  logic flush_reg;

  wire accept = (state_reg == CIES_IDLE) && INSTR_VALID;
  wire exec = (state_reg == CIES_EXEC);
  wire [CIES_DATA_W-1:0] rd = mif.rd_data;
  wire is_or = (op_reg == CIES_OP_OR);
  wire is_store = (op_reg == CIES_OP_STORE);
  wire is_copy = (op_reg == CIES_OP_COPY);
  wire is_rfi = (op_reg == CIES_OP_RFI);
  wire is_rot = (op_reg == CIES_OP_ROT);
  wire dest_op = is_or || is_copy || is_rot;
  wire [CIES_DATA_W-1:0] or_res = accum_reg | rd;
  wire [CIES_DATA_W-1:0] rot_res = {rd[CIES_DATA_W-2:0], carry_reg};
  wire rot_carry = rd[CIES_CARRY_MSB];
  wire [CIES_DATA_W-1:0] result = is_or ? or_res : (is_rot ? rot_res : rd);
  wire rfi_exec = exec && is_rfi;

  // File access: address the operand at accept, write back during execute
  assign mif.addr = accept ? INSTR_ADDR : addr_reg;
  assign mif.wr_en = exec && (is_store || (dest_op && dest_reg));
  assign mif.wr_data = is_store ? accum_reg : result;

  assign accum_next = (exec && dest_op && !dest_reg) ? result : accum_reg;
  assign zero_next = (exec && (is_or || is_copy)) ? (result == 8'h00) : zero_reg;
  assign carry_next = (exec && is_rot) ? rot_carry : carry_reg;
  // Return sets the enable and wins over a clear in the same cycle
  assign irq_en_next = rfi_exec ? 1'b1 : (GLOBAL_IRQ_CLEAR ? 1'b0 : irq_en_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CIES_IDLE: begin
        if (INSTR_VALID) begin
          state_next = CIES_EXEC;
        end
      end
      CIES_EXEC: begin
        state_next = is_rfi ? CIES_FLUSH : CIES_IDLE;
      end
      CIES_FLUSH: begin
        state_next = CIES_IDLE;
      end
      default: begin
        state_next = CIES_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= CIES_IDLE;
      ready_reg <= 1'b1;
      op_reg <= CIES_OP_IDLE;
      addr_reg <= 7'h00;
      dest_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == CIES_IDLE);
      if (accept) begin
        op_reg <= INSTR_OP;
        addr_reg <= INSTR_ADDR;
        dest_reg <= INSTR_DEST;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      accum_reg <= CIES_ACCUM_RST;
      zero_reg <= 1'b0;
      carry_reg <= 1'b0;
      irq_en_reg <= 1'b0;
    end else begin
      accum_reg <= accum_next;
      zero_reg <= zero_next;
      carry_reg <= carry_next;
      irq_en_reg <= irq_en_next;
    end
  end

  // Return side effects: load, pop and flush each a one-cycle pulse during the flush cycle; PC value held until next return
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pc_load_reg <= 1'b0;
      pc_value_reg <= CIES_PC_RST;
      pop_reg <= 1'b0;
      flush_reg <= 1'b0;
    end else begin
      pc_load_reg <= rfi_exec;
      pop_reg <= rfi_exec;
      flush_reg <= rfi_exec;
      if (rfi_exec) begin
        pc_value_reg <= STACK_TOP_ENTRY;
      end
    end
  end

  assign READY = ready_reg;
  assign ACCUM = accum_reg;
  assign ZERO_FLAG = zero_reg;
  assign CARRY_FLAG = carry_reg;
  assign GLOBAL_IRQ_ENABLE = irq_en_reg;
  assign PC_LOAD = pc_load_reg;
  assign PC_VALUE = pc_value_reg;
  assign STACK_POP = pop_reg;
  assign FETCH_FLUSH = flush_reg;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  a_or_accum: assert property (exec && is_or && !dest_reg |=> ACCUM == $past(or_res))
    else $error("OR result not in accumulator");
  a_or_file: assert property (exec && is_or && dest_reg |-> mif.wr_en && mif.wr_data == (ACCUM | rd) ##1 $stable(ACCUM))
    else $error("OR result not written back to file");
  a_zero_flag: assert property (exec && (is_or || is_copy) |=> ZERO_FLAG == ($past(result) == 8'h00))
    else $error("Zero flag wrong after OR or copy");
  a_store_file: assert property (exec && is_store |-> mif.wr_en && mif.wr_data == ACCUM && mif.addr == addr_reg ##1 $stable({ZERO_FLAG, CARRY_FLAG}))
    else $error("Store wrong or flags changed");
  a_copy_dest: assert property (exec && is_copy |=> ACCUM == ($past(dest_reg) ? $past(ACCUM) : $past(rd)))
    else $error("Copy destination wrong");
  a_rfi_pc: assert property (rfi_exec |=> PC_LOAD && PC_VALUE == $past(STACK_TOP_ENTRY) && GLOBAL_IRQ_ENABLE && $stable({ZERO_FLAG, CARRY_FLAG}))
    else $error("Return did not load PC or set enable");
  a_rot_carry: assert property (exec && is_rot |=> CARRY_FLAG == $past(rd[7]))
    else $error("Rotate carry out wrong");
  a_rot_dest: assert property (exec && is_rot && !dest_reg |=> ACCUM == {$past(rd[6:0]), $past(CARRY_FLAG)})
    else $error("Rotate result not in accumulator");
  a_idle_stable: assert property (exec && op_reg == CIES_OP_IDLE |-> !mif.wr_en ##1 READY && $stable({ACCUM, ZERO_FLAG, CARRY_FLAG}))
    else $error("Idle instruction changed state");
  a_rfi_cycles: assert property (rfi_exec |=> STACK_POP && FETCH_FLUSH && !READY ##1 READY && !STACK_POP)
    else $error("Return timing or pop wrong");

  // Sequencing, side effects and what each operation must leave alone
  a_busy_exec: assert property (
    accept |=> exec && !READY)
    else $error("Taken operation did not enter execute");
  a_exec_one_cycle: assert property (
    exec && !is_rfi |=> READY && state_reg == CIES_IDLE)
    else $error("Operation took more than one execute cycle");
  a_idle_no_write: assert property (
    !exec |-> !mif.wr_en)
    else $error("File written outside execute");
  a_rfi_flush_state: assert property (
    rfi_exec |=> state_reg == CIES_FLUSH && !READY)
    else $error("Return did not enter flush cycle");
  a_pop_source: assert property (
    STACK_POP |-> $past(rfi_exec))
    else $error("Stack pop without return");
  a_load_pairs: assert property (
    PC_LOAD |-> STACK_POP && FETCH_FLUSH)
    else $error("PC load not paired with pop and flush");
  a_pc_hold: assert property (
    !rfi_exec |=> $stable(PC_VALUE))
    else $error("PC value changed without return");
  a_enable_set_wins: assert property (
    rfi_exec && GLOBAL_IRQ_CLEAR |=> GLOBAL_IRQ_ENABLE)
    else $error("Clear won over return");
  a_enable_clear: assert property (
    GLOBAL_IRQ_CLEAR && !rfi_exec |=> !GLOBAL_IRQ_ENABLE)
    else $error("Global irq enable not cleared");
  a_store_acc_keep: assert property (
    exec && is_store |=> $stable(ACCUM))
    else $error("Store changed accumulator");
  a_zero_hold: assert property (
    exec && !(is_or || is_copy) |=> $stable(ZERO_FLAG))
    else $error("Zero flag changed by other operation");
  a_carry_hold: assert property (
    exec && !is_rot |=> $stable(CARRY_FLAG))
    else $error("Carry changed by other operation");
  a_file_dest_keep: assert property (
    exec && dest_op && dest_reg |=> $stable(ACCUM))
    else $error("File destination changed accumulator");
  a_acc_no_write: assert property (
    exec && dest_op && !dest_reg |-> !mif.wr_en)
    else $error("Accumulator destination wrote file");
  a_rot_file: assert property (
    exec && is_rot && dest_reg |-> mif.wr_en && mif.wr_data == {rd[6:0], CARRY_FLAG})
    else $error("Rotate result not written back to file");
  a_copy_self: assert property (
    exec && is_copy && dest_reg |-> mif.wr_en && mif.wr_data == rd ##1 ZERO_FLAG == ($past(rd) == 8'h00))
    else $error("Self copy wrong or zero test wrong");

  c_or_file: cover property (exec && is_or && dest_reg);
  c_rot_acc: cover property (exec && is_rot && !dest_reg);
  c_self_zero: cover property (exec && is_copy && dest_reg && rd == 8'h00);
  c_rfi: cover property (rfi_exec ##2 accept);
  c_rfi_clear: cover property (rfi_exec && GLOBAL_IRQ_CLEAR);
endmodule : cies_core
`default_nettype wire

// ### cies_pkg.sv
/*
  Shared constants and types of the instruction execute subset core.
  Assumes a single core clock and an external fetch unit that issues operations.
*/
// Function
// - OR computes accumulator OR addressed file register, address 0 to 127.
// - OR result goes to accumulator when destination 0, file when 1.
// - OR and copy-file update zero flag; self copy tests for zero.
// - Store copies accumulator into the addressed file register, no flags change.
// - Copy-file puts register in accumulator for destination 0, itself for 1.
// - Return from irq loads PC from stack top, sets global irq enable.
// - Rotate left through carry: old carry into bit 0, bit 7 out.
// - Rotate result to accumulator when destination 0, file when 1.
package cies_pkg;
  localparam int unsigned CIES_ADDR_W = 7;
  localparam int unsigned CIES_DATA_W = 8;
  localparam int unsigned CIES_PC_W = 13;
  localparam int unsigned CIES_FILE_DEPTH = 128;
  localparam logic [2:0] CIES_OP_IDLE = 3'h0;
  localparam logic [2:0] CIES_OP_OR = 3'h1;
  localparam logic [2:0] CIES_OP_STORE = 3'h2;
  localparam logic [2:0] CIES_OP_COPY = 3'h3;
  localparam logic [2:0] CIES_OP_RFI = 3'h4;
  localparam logic [2:0] CIES_OP_ROT = 3'h5;
  localparam logic [7:0] CIES_ACCUM_RST = 8'h00;
  localparam logic [12:0] CIES_PC_RST = 13'h0000;
  localparam int unsigned CIES_CARRY_MSB = 7;
  typedef enum logic [1:0] {CIES_IDLE, CIES_EXEC, CIES_FLUSH} cies_state_t;
endpackage : cies_pkg

// ### cies_mem_if.sv
/*
  Port bundle between the core and its file register memory.
  Assumes both ends sit on the same core clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface cies_mem_if;
  import cies_pkg::*;
  logic [CIES_ADDR_W-1:0] addr;
  logic wr_en;
  logic [CIES_DATA_W-1:0] wr_data;
  logic [CIES_DATA_W-1:0] rd_data;
  modport core (output addr, output wr_en, output wr_data, input rd_data);
  modport mem (input addr, input wr_en, input wr_data, output rd_data);
endinterface : cies_mem_if
`default_nettype wire

// ### cies_file_ram.sv
/*
  File register memory, 128 bytes, one port: read and write share one address.
  Assumes read data are wanted one clock after the address; contents are not reset.
*/
`timescale 1ns/1ns
`default_nettype none
module cies_file_ram
  import cies_pkg::*;
(
  input wire logic clk,
  cies_mem_if.mem port
);
  logic [CIES_DATA_W-1:0] mem_reg [CIES_FILE_DEPTH];
  logic [CIES_DATA_W-1:0] rd_reg;

  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      mem_reg[port.addr] <= port.wr_data;
    end
    rd_reg <= mem_reg[port.addr];
  end

  assign port.rd_data = rd_reg;
endmodule : cies_file_ram
`default_nettype wire

// ### core_instruction_execute_subset_tb_top.sv
/*
  Self-checking bench for the execute subset core, with an integer reference model.
  Assumes the file memory array can be preloaded by name before reset is released.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module core_instruction_execute_subset_tb_top;
  import cies_pkg::*;
  logic SYS_CLK = 1'b0, RESET_N = 1'b0, INSTR_VALID = 1'b0, INSTR_DEST = 1'b0;
  logic GLOBAL_IRQ_CLEAR = 1'b0, READY, ZERO_FLAG, CARRY_FLAG, GLOBAL_IRQ_ENABLE;
  logic PC_LOAD, STACK_POP, FETCH_FLUSH;
  logic [2:0] INSTR_OP = 3'h0;
  logic [CIES_ADDR_W-1:0] INSTR_ADDR = 7'h00;
  logic [CIES_PC_W-1:0] STACK_TOP_ENTRY = 13'h0000, PC_VALUE;
  logic [CIES_DATA_W-1:0] ACCUM;
  int mismatches = 0, n_checks = 0, acc = 0, z = 0, c = 0, ien = 0;
  int mem[128];
  always #5 SYS_CLK = ~SYS_CLK;
  cies_core dut_u (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .INSTR_VALID(INSTR_VALID),
    .INSTR_OP(INSTR_OP), .INSTR_ADDR(INSTR_ADDR), .INSTR_DEST(INSTR_DEST),
    .STACK_TOP_ENTRY(STACK_TOP_ENTRY), .GLOBAL_IRQ_CLEAR(GLOBAL_IRQ_CLEAR), .READY(READY),
    .ACCUM(ACCUM), .ZERO_FLAG(ZERO_FLAG), .CARRY_FLAG(CARRY_FLAG),
    .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE),
    .STACK_POP(STACK_POP), .FETCH_FLUSH(FETCH_FLUSH));
  task give_verdict;
    $display("TB: counts checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task tick;
    @(posedge SYS_CLK);
    #1;
  endtask : tick
  // Offer one operation, model it, then check the results at the documented cycles
  task do_op(input logic [2:0] o, input logic [6:0] a, input logic d, input logic [12:0] st);
    int k, r, nc;
    INSTR_OP = o;
    INSTR_ADDR = a;
    INSTR_DEST = d;
    STACK_TOP_ENTRY = st;
    INSTR_VALID = 1'b1;
    k = 0;
    while (READY !== 1'b1 && k < 20) begin
      tick();
      k++;
    end
    if (k == 20) begin
      mismatches++;
      give_verdict();
    end
    tick();
    INSTR_VALID = 1'b0;
    r = mem[a];
    case (o)
      CIES_OP_OR: begin r = r | acc; z = (r == 0); end
      CIES_OP_STORE: r = acc;
      CIES_OP_COPY: z = (r == 0);
      CIES_OP_RFI: ien = 1;
      CIES_OP_ROT: begin nc = (r >> 7) & 1; r = ((r << 1) | c) & 255; c = nc; end
      default: ;
    endcase
    if (o == CIES_OP_STORE || (d && (o == CIES_OP_OR || o == CIES_OP_COPY || o == CIES_OP_ROT)))
      mem[a] = r;
    else if (o == CIES_OP_OR || o == CIES_OP_COPY || o == CIES_OP_ROT) acc = r;
    tick();
    `CHK(READY, 1'(o != CIES_OP_RFI))
    if (o == CIES_OP_RFI) begin
      `CHK({PC_LOAD, STACK_POP, FETCH_FLUSH}, 3'h7)
      `CHK(PC_VALUE, st)
      `CHK(GLOBAL_IRQ_ENABLE, 1'b1)
      GLOBAL_IRQ_CLEAR = 1'b0;
      tick();
      `CHK({READY, PC_LOAD, STACK_POP, FETCH_FLUSH}, 4'h8)
    end
    `CHK(ACCUM, 8'(acc))
    `CHK({ZERO_FLAG, CARRY_FLAG, GLOBAL_IRQ_ENABLE}, 3'({z[0], c[0], ien[0]}))
  endtask : do_op
  initial begin
    void'($urandom(32'hF2725FA9));
    // Random file contents give the data path something other than zeros
    for (int i = 0; i < 128; i++) begin
      mem[i] = $urandom % 256;
      dut_u.u_ram.mem_reg[i] = 8'(mem[i]);
    end
    repeat (6) @(posedge SYS_CLK);
    #1;
    RESET_N = 1'b1;
    for (int i = 0; i < 300; i++) begin
      if ($urandom % 4 == 0) begin
        GLOBAL_IRQ_CLEAR = 1'b1;
        tick();
        GLOBAL_IRQ_CLEAR = 1'b0;
        tick();
        ien = 0;
        `CHK(GLOBAL_IRQ_ENABLE, 1'b0)
      end
      do_op(3'($urandom), 7'($urandom), 1'($urandom), 13'($urandom));
    end
    $display("TB: test random_ops done");
    // Clear held through a return: the return must still set the enable
    GLOBAL_IRQ_CLEAR = 1'b1;
    do_op(CIES_OP_RFI, 7'h00, 1'b0, 13'($urandom));
    $display("TB: test rfi_over_clear done");
    for (int i = 0; i < 128; i++) do_op(CIES_OP_STORE, 7'(i), 1'($urandom), 13'h0000);
    $display("TB: test store_all done");
    RESET_N = 1'b0;
    tick();
    `CHK({READY, PC_LOAD, STACK_POP, FETCH_FLUSH}, 4'h8)
    `CHK({ACCUM, ZERO_FLAG, CARRY_FLAG, GLOBAL_IRQ_ENABLE}, {CIES_ACCUM_RST, 3'h0})
    `CHK(PC_VALUE, CIES_PC_RST)
    tick();
    RESET_N = 1'b1;
    acc = CIES_ACCUM_RST;
    z = 0;
    c = 0;
    ien = 0;
    $display("TB: test reset_mid done");
    for (int o = 0; o < 8; o++) do_op(3'(o), 7'h7F, 1'b1, 13'h1FFF);
    $display("TB: test every_op done");
    give_verdict();
  end
endmodule : core_instruction_execute_subset_tb_top
`default_nettype wire
